/* core/sram_ctl_pkg.sv */
// shared constants, types and burst address function for the burst memory
package sram_ctl_pkg;

    // array organisation
    localparam int ADDR_W = 17;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;

    // burst counter
    localparam logic [1:0] CNT_START = 2'h0;
    localparam logic [1:0] CNT_STEP = 2'h1;

    // register bus layout
    localparam int WB_ADR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CTRL_SOFT_SLEEP_BIT = 0;
    localparam logic CTRL_SOFT_SLEEP_RESET = 1'b0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_OFFSET_LSB = 4;
    localparam int STATUS_VALID_BIT = 6;
    localparam int STATUS_ORDER_BIT = 7;

    // device activity, one-hot
    typedef enum logic [3:0] {
        ST_STANDBY = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_SLEEP = 4'b1000
    } state_t;

    // decoded operation of one clock edge
    typedef enum logic [2:0] {
        OP_DESELECT = 3'h0,
        OP_BEGIN_PROC = 3'h1,
        OP_BEGIN_CTRL = 3'h2,
        OP_CONTINUE = 3'h3,
        OP_SUSPEND = 3'h4
    } op_t;

    // low two address bits for a given burst count
    function automatic logic [1:0] burst_bits(
        input logic [1:0] base,
        input logic [1:0] cnt,
        input logic interleave
    );
        logic [1:0] sum;
        sum = base + cnt;
        return interleave ? (base ^ cnt) : sum;
    endfunction

endpackage

/* core/burst_counter.sv */
// two-bit burst counter giving the low address bits of each access
`timescale 1ns/10ps
module burst_counter (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic hold, // sleep: keep counter frozen
    input wire logic load, // begin burst at external address
    input wire logic step, // advance to next burst address
    input wire logic order, // 1 interleaved, 0 linear
    input wire logic [1:0] ext_bits, // low bits of external address
    output logic [1:0] access_bits, // low bits used this edge
    output logic [1:0] count // current burst count
);
    logic [1:0] base_reg;
    logic [1:0] base_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic [1:0] cnt_inc;

    // next count and base, and the address bits used on this edge
    always_comb begin
        cnt_inc = cnt_reg + sram_ctl_pkg::CNT_STEP;
        base_next = base_reg;
        cnt_next = cnt_reg;
        access_bits = sram_ctl_pkg::burst_bits(base_reg, cnt_reg, order); // RULE_07
        if (hold) begin
            base_next = base_reg;
        end else if (load) begin
            base_next = ext_bits;
            cnt_next = sram_ctl_pkg::CNT_START;
            access_bits = ext_bits;
        end else if (step) begin
            cnt_next = cnt_inc; // RULE_15
            access_bits = sram_ctl_pkg::burst_bits(base_reg, cnt_inc, order); // RULE_13 RULE_14
        end
    end

    // counter registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_reg <= 2'h0;
            cnt_reg <= 2'h0;
        end else begin
            base_reg <= base_next;
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg;

endmodule

/* core/sync_burst_sram_control.sv */
// control, burst addressing, storage array and data pins of the burst memory
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - strobe low without valid select deselects, floats pins, standby
// RULE_02 - selected with processor strobe low: latch address, read, ignore writes
// RULE_03 - controller strobe begins read burst unless writes requested
// RULE_04 - controller strobe begins write burst when global or gated lane write
// RULE_05 - no new address, advance low, no write: step and read
// RULE_06 - no new address, advance low, write requested: step and write
// RULE_07 - advance high keeps burst address and reads or writes there
// RULE_08 - global write writes all lanes; otherwise gate high or no lanes reads
// RULE_09 - gate low writes exactly the lanes enabled, any combination
// RULE_10 - output enable acts unclocked in reads; writes leave pins undriven
// RULE_11 - sleep input floats data pins whatever output enable does
// RULE_12 - clocked operations decoded only while sleep input is low
// RULE_13 - interleaved order: start bits xor counter 0,1,2,3
// RULE_14 - linear order: start bits plus counter modulo four
// RULE_15 - after fourth address the burst wraps to its start
// RULE_16 - undriven order input reads high, undriven sleep input reads low
// RULE_17 - host holds clocked controls consistent while using enable or sleep
// RULE_18 - read data held in output register, presented one clock later
// RULE_19 - four nine-bit lanes, each lane enable controls one lane
// RULE_20 - any active lane write disables all data output drivers
// RULE_21 - host keeps order input static while operating
// RULE_22 - burst counter changes only two low address bits
module sync_burst_sram_control #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W, // word address width
    parameter int LANES = sram_ctl_pkg::LANES, // byte lanes per word
    parameter int LANE_W = sram_ctl_pkg::LANE_W // bits per lane
) (
    input wire logic CLK_SYS, // system clock
    input wire logic RST, // async reset, active high
    input wire logic [ADDR_W-1:0] ADDR, // external address
    input wire logic CE_N, // chip enable, low active
    input wire logic SELECT_HIGH, // chip select, high active
    input wire logic SELECT_LOW_N, // chip select, low active
    input wire logic PROC_ADDR_STROBE_N, // processor address strobe
    input wire logic CTRL_ADDR_STROBE_N, // controller address strobe
    input wire logic BURST_STEP_N, // burst advance, low active
    input wire logic ALL_BYTE_WRITE_N, // global write, low active
    input wire logic BYTE_WRITE_GATE_N, // byte write gate, low active
    input wire logic [LANES-1:0] LANE_WRITE_N, // per-lane write, low active
    input wire logic OE_N, // output enable, low active, unclocked
    input wire logic SLEEP_REQ, // sleep request, high active
    input wire logic ORDER_SELECT, // 1 interleaved, 0 linear
    input wire logic [LANES*LANE_W-1:0] DQ_I, // data pins, input side
    output logic [LANES*LANE_W-1:0] DQ_O, // data pins, output side
    output logic DQ_OE, // data pins drive enable, high drives
    input wire logic WB_CYC_I, // wishbone cycle
    input wire logic WB_STB_I, // wishbone strobe
    input wire logic WB_WE_I, // wishbone write enable
    input wire logic [sram_ctl_pkg::WB_ADR_W-1:0] WB_ADR_I, // byte address
    input wire logic [31:0] WB_DAT_I, // wishbone write data
    input wire logic [3:0] WB_SEL_I, // wishbone byte selects
    output logic [31:0] WB_DAT_O, // wishbone read data
    output logic WB_ACK_O // wishbone acknowledge
);
    localparam int DATA_W = LANES * LANE_W;

    // storage array, no reset
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    sram_ctl_pkg::state_t state_reg;
    sram_ctl_pkg::state_t state_next;
    sram_ctl_pkg::op_t op;
    logic [ADDR_W-3:0] upper_reg;
    logic [ADDR_W-3:0] upper_next;
    logic valid_reg;
    logic valid_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic soft_sleep_reg;
    logic soft_sleep_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_o_reg;
    logic [31:0] dat_o_next;

    logic selected;
    logic write_req;
    logic [LANES-1:0] lane_we;
    logic sleep_eff;
    logic do_access;
    logic do_write;
    logic load;
    logic step;
    logic [1:0] access_bits;
    logic [1:0] burst_count;
    logic [ADDR_W-3:0] access_upper;
    logic [ADDR_W-1:0] access_addr;
    logic [DATA_W-1:0] wr_word;
    logic wb_req;
    logic wb_wr;

    // selection and write decode of the current edge
    always_comb begin
        selected = ~CE_N & SELECT_HIGH & ~SELECT_LOW_N;
        // global write overrides gate and lanes; gate high blocks lanes
        if (!ALL_BYTE_WRITE_N) begin
            lane_we = {LANES{1'b1}}; // RULE_08
        end else if (!BYTE_WRITE_GATE_N) begin
            lane_we = ~LANE_WRITE_N; // RULE_09 RULE_19
        end else begin
            lane_we = {LANES{1'b0}}; // RULE_08
        end
        write_req = |lane_we;
    end

    // operation decode from strobes and selects
    always_comb begin
        if (!CTRL_ADDR_STROBE_N && CE_N) begin
            op = sram_ctl_pkg::OP_DESELECT; // RULE_01
        end else if (!CE_N && !selected
                     && (!PROC_ADDR_STROBE_N || !CTRL_ADDR_STROBE_N)) begin
            op = sram_ctl_pkg::OP_DESELECT; // RULE_01
        end else if (!CE_N && !PROC_ADDR_STROBE_N) begin
            op = sram_ctl_pkg::OP_BEGIN_PROC; // RULE_02
        end else if (!CTRL_ADDR_STROBE_N) begin
            op = sram_ctl_pkg::OP_BEGIN_CTRL; // RULE_03 RULE_04
        end else if (!BURST_STEP_N) begin
            op = sram_ctl_pkg::OP_CONTINUE; // RULE_05 RULE_06
        end else begin
            op = sram_ctl_pkg::OP_SUSPEND; // RULE_07
        end
    end

    // sleep from the pin or from software; pin pull-down sits at the pad
    assign sleep_eff = SLEEP_REQ | soft_sleep_reg; // RULE_16

    // access control: which edges touch the array and how
    always_comb begin
        load = 1'b0;
        step = 1'b0;
        do_access = 1'b0;
        do_write = 1'b0;
        if (!sleep_eff) begin // RULE_12
            unique case (op)
                sram_ctl_pkg::OP_DESELECT: begin
                    do_access = 1'b0;
                end
                sram_ctl_pkg::OP_BEGIN_PROC: begin
                    load = 1'b1;
                    do_access = 1'b1; // RULE_02
                end
                sram_ctl_pkg::OP_BEGIN_CTRL: begin
                    load = 1'b1;
                    do_access = 1'b1;
                    do_write = write_req; // RULE_03 RULE_04
                end
                sram_ctl_pkg::OP_CONTINUE: begin
                    step = valid_reg;
                    do_access = valid_reg;
                    do_write = valid_reg & write_req; // RULE_05 RULE_06
                end
                sram_ctl_pkg::OP_SUSPEND: begin
                    do_access = valid_reg;
                    do_write = valid_reg & write_req; // RULE_07
                end
            endcase
        end
    end

    burst_counter u_burst_counter (
        .clk(CLK_SYS),
        .rst(RST),
        .hold(sleep_eff),
        .load(load),
        .step(step),
        .order(ORDER_SELECT),
        .ext_bits(ADDR[1:0]),
        .access_bits(access_bits),
        .count(burst_count)
    );

    // full word address: upper bits fixed for the whole burst
    always_comb begin
        access_upper = load ? ADDR[ADDR_W-1:2] : upper_reg; // RULE_22
        access_addr = {access_upper, access_bits}; // RULE_22
    end

    // merge of written lanes into the stored word
    always_comb begin
        wr_word = mem[access_addr];
        for (int i = 0; i < LANES; i++) begin
            if (lane_we[i]) begin
                wr_word[i*LANE_W +: LANE_W] = DQ_I[i*LANE_W +: LANE_W]; // RULE_19
            end
        end
    end

    // next activity, burst validity and output register
    always_comb begin
        state_next = state_reg;
        upper_next = upper_reg;
        valid_next = valid_reg;
        rd_data_next = rd_data_reg;
        if (sleep_eff) begin
            state_next = sram_ctl_pkg::ST_SLEEP; // RULE_11 RULE_12
            valid_next = 1'b0;
        end else if (op == sram_ctl_pkg::OP_DESELECT) begin
            state_next = sram_ctl_pkg::ST_STANDBY; // RULE_01
            valid_next = 1'b0;
        end else if (!do_access) begin
            state_next = sram_ctl_pkg::ST_STANDBY;
        end else if (do_write) begin
            state_next = sram_ctl_pkg::ST_WRITE;
        end else begin
            state_next = sram_ctl_pkg::ST_READ;
            rd_data_next = mem[access_addr]; // RULE_18
        end
        if (load) begin
            upper_next = ADDR[ADDR_W-1:2];
            valid_next = 1'b1;
        end
    end

    // array write on the edge that decodes a write
    always_ff @(posedge CLK_SYS) begin
        if (do_write) begin
            mem[access_addr] <= wr_word; // RULE_04 RULE_06 RULE_09
        end
    end

    // control and data registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_reg <= sram_ctl_pkg::ST_STANDBY;
            upper_reg <= '0;
            valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end else begin
            state_reg <= state_next;
            upper_reg <= upper_next;
            valid_reg <= valid_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // read data comes straight from the output register
    assign DQ_O = rd_data_reg; // RULE_18

    // driver enable: unclocked output enable, floated in sleep and writes
    always_comb begin
        DQ_OE = (state_reg == sram_ctl_pkg::ST_READ) & ~OE_N; // RULE_10
        if (sleep_eff) begin
            DQ_OE = 1'b0; // RULE_11
        end
        if (do_write || write_req) begin
            DQ_OE = 1'b0; // RULE_10 RULE_20
        end
    end

    // register bus: ack one cycle after the request edge; a write lands on
    // the edge at which the master samples ack, never before it
    always_comb begin
        wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;
        wb_wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;
        ack_next = wb_req;
        soft_sleep_next = soft_sleep_reg;
        dat_o_next = dat_o_reg;
        if (wb_wr && WB_ADR_I == sram_ctl_pkg::REG_CTRL && WB_SEL_I[0]) begin
            soft_sleep_next = WB_DAT_I[sram_ctl_pkg::CTRL_SOFT_SLEEP_BIT];
        end
        // read data is ready by the edge at which ack is sampled
        if (wb_req && !WB_WE_I) begin
            dat_o_next = 32'h0;
            if (WB_ADR_I == sram_ctl_pkg::REG_CTRL) begin
                dat_o_next[sram_ctl_pkg::CTRL_SOFT_SLEEP_BIT] =
                    soft_sleep_reg;
            end else if (WB_ADR_I == sram_ctl_pkg::REG_STATUS) begin
                dat_o_next[sram_ctl_pkg::STATUS_STATE_LSB +: 4] = state_reg;
                dat_o_next[sram_ctl_pkg::STATUS_OFFSET_LSB +: 2] =
                    burst_count;
                dat_o_next[sram_ctl_pkg::STATUS_VALID_BIT] = valid_reg;
                dat_o_next[sram_ctl_pkg::STATUS_ORDER_BIT] = ORDER_SELECT;
            end
        end
    end

    // register bus state
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ack_reg <= 1'b0;
            dat_o_reg <= 32'h0;
            soft_sleep_reg <= sram_ctl_pkg::CTRL_SOFT_SLEEP_RESET;
        end else begin
            ack_reg <= ack_next;
            dat_o_reg <= dat_o_next;
            soft_sleep_reg <= soft_sleep_next;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_o_reg;

endmodule

/* test/sram_ctl_asserts.sv */
// concurrent checks on the data pin enable and the register bus handshake
`timescale 1ns/10ps
module sram_ctl_asserts #(
    parameter int LANES = sram_ctl_pkg::LANES // byte lanes per word
) (
    input wire logic CLK_SYS, // system clock
    input wire logic RST, // async reset
    input wire logic CE_N, // chip enable
    input wire logic SELECT_HIGH, // high select
    input wire logic SELECT_LOW_N, // low select
    input wire logic PROC_ADDR_STROBE_N, // processor strobe
    input wire logic CTRL_ADDR_STROBE_N, // controller strobe
    input wire logic ALL_BYTE_WRITE_N, // global write
    input wire logic BYTE_WRITE_GATE_N, // lane gate
    input wire logic [LANES-1:0] LANE_WRITE_N, // lane writes
    input wire logic OE_N, // output enable
    input wire logic SLEEP_REQ, // sleep
    input wire logic DQ_OE, // pin drive enable
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // bus strobe
    input wire logic WB_ACK_O // bus acknowledge
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic wr_req;
    logic chosen;
    logic sel_ok;
    logic desel;
    // decode of write request, selection and deselect on the inputs
    assign wr_req = !ALL_BYTE_WRITE_N ||
        (!BYTE_WRITE_GATE_N && !(&LANE_WRITE_N));
    assign chosen = SELECT_HIGH && !SELECT_LOW_N;
    assign sel_ok = !CE_N && chosen;
    assign desel = (CE_N && !CTRL_ADDR_STROBE_N) || (!CE_N && !chosen &&
        !(PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N));
    sleep_float_a: assert property (SLEEP_REQ |-> !DQ_OE)
        else $error("pins driven during sleep");
    oe_float_a: assert property (OE_N |-> !DQ_OE)
        else $error("pins driven with output enable high");
    write_float_a: assert property (wr_req |-> !DQ_OE)
        else $error("pins driven while a write is requested");
    deselect_float_a: assert property (!SLEEP_REQ && desel |=> !DQ_OE)
        else $error("pins driven after deselect");
    ctrl_read_a: assert property (sel_ok && PROC_ADDR_STROBE_N &&
        !CTRL_ADDR_STROBE_N && !wr_req && !SLEEP_REQ ##1
        (!OE_N && !SLEEP_REQ && !wr_req) |-> DQ_OE)
        else $error("controller read did not drive pins");
    proc_read_a: assert property (sel_ok && !PROC_ADDR_STROBE_N &&
        !SLEEP_REQ ##1 (!OE_N && !SLEEP_REQ && !wr_req) |-> DQ_OE)
        else $error("processor begin did not read");
    wake_idle_a: assert property (SLEEP_REQ ##1 (!SLEEP_REQ &&
        CTRL_ADDR_STROBE_N && (CE_N || PROC_ADDR_STROBE_N)) |=> !DQ_OE)
        else $error("burst resumed after sleep");
    ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");
    ack_time_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("acknowledge not one cycle after request");
endmodule
bind sync_burst_sram_control sram_ctl_asserts #(.LANES(LANES)) u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE_N(CE_N), .SELECT_HIGH(SELECT_HIGH),
    .SELECT_LOW_N(SELECT_LOW_N), .PROC_ADDR_STROBE_N(PROC_ADDR_STROBE_N),
    .CTRL_ADDR_STROBE_N(CTRL_ADDR_STROBE_N), .ALL_BYTE_WRITE_N(ALL_BYTE_WRITE_N),
    .BYTE_WRITE_GATE_N(BYTE_WRITE_GATE_N), .LANE_WRITE_N(LANE_WRITE_N),
    .OE_N(OE_N), .SLEEP_REQ(SLEEP_REQ), .DQ_OE(DQ_OE), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));

/* test/dq_bus_model.sv */
// data pin bus as the host side sees it
`timescale 1ns/10ps
module dq_bus_model #(
    parameter int W = 36 // pin count
) (
    input wire logic clk, // system clock
    input wire logic [W-1:0] dev_data, // device output side
    input wire logic dev_oe, // device drives
    input wire logic host_en, // host drives write data
    input wire logic [W-1:0] host_data, // host write data
    output logic [W-1:0] bus // resolved pin level
);
    logic [W-1:0] last_reg = '0;
    // released pins show the inverse of their last level, never a held value
    always_comb begin
        if (dev_oe) begin
            bus = dev_data;
        end else if (host_en) begin
            bus = host_data;
        end else begin
            bus = ~last_reg;
        end
    end
    always @(posedge clk) begin
        last_reg <= bus;
    end
endmodule

/* test/tb.sv */
// self-checking bench: burst reads and writes, sleep, register bus
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb;
    logic clk_sys = 0, rst = 1, ce_n = 1, sel_hi = 1, proc_addr_strobe_n_n = 1, ctrl_addr_strobe_n_n = 0;
    logic adv_n = 1, gw_n = 1, bwe_n = 1, oe_n = 0, zz = 0, ord_sel = 1;
    logic cyc = 0, stb = 0, we = 0, hen = 0, dq_oe, ack, ord, pend, bval;
    logic sel_lo_n = 0;
    logic [3:0] bw_n = 4'hf, adr = 4'h0;
    logic [16:0] addr = '0, base;
    logic [35:0] hdata = '0, dq_i, dq_o, pend_exp;
    logic [31:0] wdat = '0, rdat, rd;
    logic [1:0] cnt;
    logic [35:0] mem_model [int];
    int bad_count = 0, samples_checked = 0;
    sync_burst_sram_control DUT (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr),
        .CE_N(ce_n), .SELECT_HIGH(sel_hi), .SELECT_LOW_N(sel_lo_n),
        .PROC_ADDR_STROBE_N(proc_addr_strobe_n_n), .CTRL_ADDR_STROBE_N(ctrl_addr_strobe_n_n),
        .BURST_STEP_N(adv_n), .ALL_BYTE_WRITE_N(gw_n), .BYTE_WRITE_GATE_N(bwe_n),
        .LANE_WRITE_N(bw_n), .OE_N(oe_n), .SLEEP_REQ(zz), .ORDER_SELECT(ord_sel),
        .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'hf),
        .WB_DAT_O(rdat), .WB_ACK_O(ack));
    dq_bus_model #(.W(36)) u_bus (.clk(clk_sys), .dev_data(dq_o),
        .dev_oe(dq_oe), .host_en(hen), .host_data(hdata), .bus(dq_i));
    // free-running system clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // one wishbone classic cycle, held until acknowledge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask
    // one memory edge; kind 0 deselect 1 proc 2 ctrl 3 continue 4 suspend
    task automatic mem_op(input int kind, input logic gw, input logic [3:0] bw,
        input logic [16:0] a, input logic [35:0] d);
        logic [16:0] acc;
        logic wr;
        wr = !gw || (bw != 4'hf);
        ce_n <= (kind == 0) && ord;
        sel_hi <= (kind != 0) || ord || a[0];
        sel_lo_n <= (kind == 0) && !ord && a[0];
        proc_addr_strobe_n_n <= (kind != 1);
        ctrl_addr_strobe_n_n <= (kind == 1) || (kind > 2);
        adv_n <= (kind != 3);
        gw_n <= gw;
        bwe_n <= (bw == 4'hf);
        bw_n <= bw;
        addr <= a;
        hdata <= d;
        hen <= wr;
        @(posedge clk_sys);
        `CHK("pin enable", pend && !oe_n && !wr && !zz, dq_oe)
        if (pend) `CHK("read data", pend_exp, dq_o)
        pend = 0;
        if (zz || kind == 0) bval = 0;
        else if (kind < 3) begin
            base = a;
            cnt = 2'h0;
            bval = 1;
        end else if (kind == 3) cnt = cnt + 2'h1;
        if (!zz && kind != 0 && bval) begin
            acc = {base[16:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
            if (wr && kind != 1) begin
                for (int i = 0; i < 4; i++)
                    if (!gw || !bw[i]) mem_model[acc][9*i +: 9] = d[9*i +: 9];
            end else begin
                pend = 1;
                pend_exp = mem_model[acc];
            end
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // run limit
    initial begin
        repeat (3000) @(posedge clk_sys);
        bad_count++;
        print_verdict();
    end
    // main sequence, once per burst order
    initial begin
        for (int o = 1; o >= 0; o--) begin
            ord = o[0];
            pend = 0;
            bval = 0;
            ord_sel <= ord;
            rst <= 1'b1;
            repeat (5) @(posedge clk_sys);
            rst <= 1'b0;
            wb(1'b0, 4'h0, 32'h0);
            `CHK("ctrl", 32'h0, rd)
            wb(1'b1, 4'hc, 32'hff);
            wb(1'b0, 4'hc, 32'h0);
            `CHK("unmapped", 32'h0, rd)
            wb(1'b0, 4'h4, 32'h0);
            `CHK("status", {24'h0, ord, 7'h01}, rd)
            wb(1'b1, 4'h0, 32'h1);
            wb(1'b0, 4'h4, 32'h0);
            `CHK("sleep status", 5'h08, {rd[6], rd[3:0]})
            wb(1'b1, 4'h0, 32'h0);
            // start offset 1 makes linear and interleaved orders differ
            for (int i = 0; i < 5; i++)
                mem_op(i ? 3 : 2, i == 4, i == 4 ? 4'h0 : 4'hf, 17'h1a5,
                    36'h5a5a5a5a5 + 36'(i) * 36'h010101010);
            mem_op(4, 1'b1, ord ? 4'h5 : 4'ha, 17'h0, 36'hfffffffff);
            mem_op(1, 1'b0, 4'hf, 17'h1a5, 36'h0);
            for (int i = 0; i < 5; i++) mem_op(3, 1'b1, 4'hf, 17'h0, 36'h0);
            oe_n <= 1'b1;
            mem_op(4, 1'b1, 4'hf, 17'h0, 36'h0);
            oe_n <= 1'b0;
            mem_op(0, 1'b1, 4'hf, 17'h0, 36'h0);
            mem_op(3, 1'b1, 4'hf, 17'h0, 36'h0);
            zz <= 1'b1;
            mem_op(2, 1'b0, 4'hf, 17'h1a5, 36'h0);
            zz <= 1'b0;
            mem_op(3, 1'b1, 4'hf, 17'h0, 36'h0);
            mem_op(2, 1'b1, 4'hf, 17'h1a5, 36'h0);
            mem_op(0, 1'b1, 4'hf, 17'h1, 36'h0);
        end
        print_verdict();
    end
endmodule
